//--- rtl/buck_ctrl_pkg.sv
// Function
// - Enable selector naming a pin turns the regulator on at rise, off at fall.
// - Selector 00 leaves sequencer control; 01 pin one, 10 pin two, 11 pin thirteen.
// - Voltage selector naming a pin picks target A at rise, target B at fall.
// - Bit 0 is the live enable; 0 turns the buck off, 1 on.
// - Bit 3 holds the sequencer target enable, apart from the live enable.
// - Core A bit 4 drives the rail switch; 0 opens, 1 closes.
// - Core A bit 7 holds the sequencer target of the rail switch.
// - Core B register is ignored while the core bucks run dual-phase.
// - Memory buck sequencer target acts only when it is a default supply.
// - Memory buck gets the same pin-driven enable and disable behaviour.
`default_nettype none

package buck_ctrl_pkg;

    // ****************************************
    // Sizes and register indices
    // ****************************************
    localparam int NUM_REGS    = 4;
    localparam int NUM_PINS    = 3;
    localparam int SLOT_CORE_B = 0;
    localparam int SLOT_CORE_A = 1;
    localparam int SLOT_MEM    = 3;

    // Byte address is four times the index
    localparam logic [29:0] SLOT_IDX [NUM_REGS] = '{30'h20, 30'h21, 30'h22, 30'h23};
    localparam logic [29:0] IDX_CFG  = 30'h30;
    localparam logic [29:0] IDX_STAT = 30'h31;

    // ****************************************
    // Control byte fields
    // ****************************************
    localparam int BIT_EN      = 0;
    localparam int EN_SEL_LSB  = 1;
    localparam int BIT_CONF    = 3;
    localparam int BIT_SW_EN   = 4;
    localparam int VSEL_LSB    = 5;
    localparam int BIT_SW_CONF = 7;

    localparam logic [1:0] SEL_NONE  = 2'h0;
    localparam logic [1:0] SEL_PIN1  = 2'h1;
    localparam logic [1:0] SEL_PIN2  = 2'h2;
    localparam logic [1:0] SEL_PIN13 = 2'h3;

    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] MASK_FULL  = 8'hff;
    localparam logic [7:0] MASK_PLAIN = 8'h6f;

    // ****************************************
    // Configuration and status fields
    // ****************************************
    localparam int         CFG_DUAL   = 0;
    localparam int         CFG_MEMDEF = 1;
    localparam logic [1:0] CFG_RESET  = 2'h0;
    localparam int STAT_EN_LSB  = 0;
    localparam int STAT_SW      = 4;
    localparam int STAT_VA_LSB  = 5;
    localparam int STAT_PIN_LSB = 9;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS   = 100;
    localparam int DEBOUNCE_NS     = 2000;
    localparam int DEBOUNCE_CYCLES = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [4:0] DEB_LAST = 5'(DEBOUNCE_CYCLES - 1);

    localparam logic HRESP_OKAY = 1'b0;

    // Pick the event of the pin a selector names
    function automatic logic pick_pin(input logic [1:0] sel, input logic [2:0] v);
        case (sel)
            SEL_PIN1:  pick_pin = v[0];
            SEL_PIN2:  pick_pin = v[1];
            SEL_PIN13: pick_pin = v[2];
            default:   pick_pin = 1'b0;
        endcase
    endfunction : pick_pin

endpackage : buck_ctrl_pkg

`default_nettype wire

//--- rtl/pin_debounce.sv
`default_nettype none

module pin_debounce
    import buck_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic                hclk,
    input  wire logic                hresetn,
    // Raw pins
    input  wire logic [NUM_PINS-1:0] pin_raw,
    // Filtered level and edges
    output logic      [NUM_PINS-1:0] pin_level,
    output logic      [NUM_PINS-1:0] pin_rise,
    output logic      [NUM_PINS-1:0] pin_fall
);

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // ****************************************
    // One filter per pin
    // ****************************************
    for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
        logic       level_ff;
        logic       rise_ff;
        logic       fall_ff;
        logic [4:0] cnt_ff;
        wire logic  differs = pin_raw[g] != level_ff;
        wire logic  settle  = differs && (cnt_ff == DEB_LAST);

        // Glitches shorter than the window restart the count
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                level_ff <= 1'b0;
                cnt_ff   <= 5'h00;
                rise_ff  <= 1'b0;
                fall_ff  <= 1'b0;
            end else begin
                cnt_ff   <= (differs && !settle) ? cnt_ff + 5'h01 : 5'h00;
                level_ff <= settle ? pin_raw[g] : level_ff;
                rise_ff  <= settle && pin_raw[g];
                fall_ff  <= settle && !pin_raw[g];
            end
        end

        assign pin_level[g] = level_ff;
        assign pin_rise[g]  = rise_ff;
        assign pin_fall[g]  = fall_ff;

        AST_RISE_FROM_LEVEL: assert property (
            rise_ff |-> level_ff && !$past(level_ff))
            else $error("rise pulse without level change");
        AST_EDGE_ONE_CYCLE: assert property (
            (rise_ff || fall_ff) |=> !(rise_ff || fall_ff) [*2])
            else $error("edge pulse repeated");
    end

endmodule : pin_debounce

`default_nettype wire

//--- rtl/buck_slot.sv
`default_nettype none

module buck_slot
    import buck_ctrl_pkg::*;
#(
    parameter logic [7:0] WR_MASK    = MASK_PLAIN,
    parameter bit         HAS_SWITCH = 1'b0
) (
    // Clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // Software write
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    // Pin events
    input  wire logic [2:0] pin_rise,
    input  wire logic [2:0] pin_fall,
    // Sequencer and gating
    input  wire logic       seq_apply,
    input  wire logic       seq_allowed,
    input  wire logic       blocked,
    // State
    output logic      [7:0] ctrl_q,
    output logic            volt_a_q
);

    logic [7:0] ctrl_ff;
    logic [7:0] nxt_ctrl;
    logic       volt_a_ff;
    logic       nxt_volt_a;

    // ****************************************
    // Event decode
    // ****************************************
    wire logic [1:0] en_sel = ctrl_ff[EN_SEL_LSB +: 2];
    wire logic [1:0] v_sel  = ctrl_ff[VSEL_LSB +: 2];
    wire logic       en_on  = !blocked && pick_pin(en_sel, pin_rise);
    wire logic       en_off = !blocked && pick_pin(en_sel, pin_fall);
    wire logic       v_on   = !blocked && pick_pin(v_sel, pin_rise);
    wire logic       v_off  = !blocked && pick_pin(v_sel, pin_fall);
    // Sequencer only drives a regulator left without pin control
    wire logic       seq_go = seq_apply && seq_allowed && !blocked
                              && en_sel == SEL_NONE;
    wire logic       sw_go  = HAS_SWITCH && seq_apply && !blocked;
    // Reserved bits keep their reset value
    wire logic [7:0] wr_val = (ctrl_ff & ~WR_MASK) | (wr_data & WR_MASK);
    wire logic [7:0] base   = (wr_en && !blocked) ? wr_val : ctrl_ff;

    // Pin edges win over a write in the same cycle
    always_comb begin
        nxt_ctrl   = base;
        nxt_volt_a = volt_a_ff;
        if (seq_go) begin
            nxt_ctrl[BIT_EN] = ctrl_ff[BIT_CONF];
        end
        if (sw_go) begin
            nxt_ctrl[BIT_SW_EN] = ctrl_ff[BIT_SW_CONF];
        end
        if (en_on) begin
            nxt_ctrl[BIT_EN] = 1'b1;
        end else if (en_off) begin
            nxt_ctrl[BIT_EN] = 1'b0;
        end
        if (v_on) begin
            nxt_volt_a = 1'b1;
        end else if (v_off) begin
            nxt_volt_a = 1'b0;
        end
    end

    // State registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_ff   <= CTRL_RESET;
            volt_a_ff <= 1'b0;
        end else begin
            ctrl_ff   <= nxt_ctrl;
            volt_a_ff <= nxt_volt_a;
        end
    end

    assign ctrl_q   = ctrl_ff;
    assign volt_a_q = volt_a_ff;

endmodule : buck_slot

`default_nettype wire

//--- rtl/buck_regulator_control_regs.sv
`default_nettype none

module buck_regulator_control_regs
    import buck_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,

    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic      [31:0] hrdata,
    output logic             hresp,

    // General pins
    input  wire logic        general_pin_one,
    input  wire logic        general_pin_two,
    input  wire logic        general_pin_thirteen,

    // Start-up sequencer
    input  wire logic        seq_apply,

    // Regulator enables
    output logic             core_b_buck_on,
    output logic             core_a_buck_on,
    output logic             processor_buck_on,
    output logic             memory_buck_on,
    output logic             processor_rail_switch_closed,

    // Target voltage A chosen
    output logic             core_b_target_a,
    output logic             core_a_target_a,
    output logic             processor_target_a,
    output logic             memory_target_a
);

    // ****************************************
    // Declarations
    // ****************************************
    logic [7:0]          ctrl_q [NUM_REGS];
    logic [NUM_REGS-1:0] volt_a_q;
    logic [NUM_REGS-1:0] wr_slot;
    logic [NUM_PINS-1:0] pin_level;
    logic [NUM_PINS-1:0] pin_rise;
    logic [NUM_PINS-1:0] pin_fall;
    logic [31:0]         rd_data;

    // Bus slave state
    logic                wr_pend_ff;
    logic [29:0]         wr_idx_ff;
    logic [31:0]         hrdata_ff;
    logic                hready_ff;
    logic                hresp_ff;

    // Configuration and output flops
    logic [1:0]          cfg_ff;
    logic [NUM_REGS-1:0] on_ff;
    logic [NUM_REGS-1:0] va_ff;
    logic                rail_ff;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // ****************************************
    // Pin conditioning
    // ****************************************
    pin_debounce u_pins (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .pin_raw   ({general_pin_thirteen, general_pin_two, general_pin_one}),
        .pin_level (pin_level),
        .pin_rise  (pin_rise),
        .pin_fall  (pin_fall)
    );

    // ****************************************
    // Bus slave
    // ****************************************
    // Only NONSEQ or SEQ transfers with hready high are taken
    wire logic        take    = hsel && hready && htrans[1];
    wire logic [29:0] rd_idx  = haddr[31:2];
    wire logic        dual    = cfg_ff[CFG_DUAL];
    wire logic        wr_cfg  = wr_pend_ff && wr_idx_ff == IDX_CFG;

    // Core B reads zero while merged
    wire logic [7:0]  core_b_view = dual ? 8'h00 : ctrl_q[SLOT_CORE_B];

    // Status shows live outputs and filtered pins
    wire logic [31:0] stat_word = {20'h00000, pin_level, va_ff, rail_ff, on_ff};

    // Unmapped addresses read zero, so software can probe without side effects
    always_comb begin
        if (rd_idx == SLOT_IDX[0]) begin
            rd_data = {24'h000000, core_b_view};
        end else if (rd_idx == SLOT_IDX[1]) begin
            rd_data = {24'h000000, ctrl_q[1]};
        end else if (rd_idx == SLOT_IDX[2]) begin
            rd_data = {24'h000000, ctrl_q[2]};
        end else if (rd_idx == SLOT_IDX[3]) begin
            rd_data = {24'h000000, ctrl_q[3]};
        end else if (rd_idx == IDX_CFG) begin
            rd_data = {30'h0, cfg_ff};
        end else if (rd_idx == IDX_STAT) begin
            rd_data = stat_word;
        end else begin
            rd_data = 32'h00000000;
        end
    end

    // Address phase is captured; write data lands one cycle later
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_idx_ff  <= 30'h0;
            hrdata_ff  <= 32'h00000000;
            hready_ff  <= 1'b1;
            hresp_ff   <= HRESP_OKAY;
        end else begin
            wr_pend_ff <= take && hwrite;
            wr_idx_ff  <= take ? rd_idx : wr_idx_ff;
            hrdata_ff  <= (take && !hwrite) ? rd_data : 32'h00000000;
            hready_ff  <= 1'b1;
            hresp_ff   <= HRESP_OKAY;
        end
    end

    // Configuration register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_ff <= CFG_RESET;
        end else if (wr_cfg) begin
            cfg_ff <= hwdata[1:0];
        end
    end

    assign hreadyout = hready_ff;
    assign hrdata    = hrdata_ff;
    assign hresp     = hresp_ff;

    // ****************************************
    // Regulator slots
    // ****************************************
    // Memory slot shares the pin path of the others
    for (genvar g = 0; g < NUM_REGS; g++) begin : g_slot
        localparam bit SW = (g == SLOT_CORE_A);
        wire logic blk   = (g == SLOT_CORE_B) && dual;
        wire logic allow = (g != SLOT_MEM) || cfg_ff[CFG_MEMDEF];
        wire logic [1:0] es = ctrl_q[g][EN_SEL_LSB +: 2];
        wire logic [1:0] vs = ctrl_q[g][VSEL_LSB +: 2];
        wire logic any_en = pick_pin(es, pin_rise | pin_fall);

        assign wr_slot[g] = wr_pend_ff && wr_idx_ff == SLOT_IDX[g];

        buck_slot #(
            .WR_MASK    (SW ? MASK_FULL : MASK_PLAIN),
            .HAS_SWITCH (SW)
        ) u_slot (
            .hclk        (hclk),
            .hresetn     (hresetn),
            .wr_en       (wr_slot[g]),
            .wr_data     (hwdata[7:0]),
            .pin_rise    (pin_rise),
            .pin_fall    (pin_fall),
            .seq_apply   (seq_apply),
            .seq_allowed (allow),
            .blocked     (blk),
            .ctrl_q      (ctrl_q[g]),
            .volt_a_q    (volt_a_q[g])
        );

        AST_EN_RISE: assert property (
            !blk && pick_pin(es, pin_rise) |=> ctrl_q[g][BIT_EN])
            else $error("pin rise did not enable");
        AST_EN_FALL: assert property (
            !blk && pick_pin(es, pin_fall) |=> !ctrl_q[g][BIT_EN])
            else $error("pin fall did not disable");
        AST_EN_REACHES_OUT: assert property (
            !blk && !dual && pick_pin(es, pin_rise) |-> ##2 on_ff[g])
            else $error("enable output missed pin rise");
        AST_NONE_HOLDS: assert property (
            es == SEL_NONE && !wr_slot[g] && !seq_apply
            |=> $stable(ctrl_q[g][BIT_EN]))
            else $error("enable moved without cause");
        AST_VOLT_A: assert property (
            !blk && pick_pin(vs, pin_rise) |=> volt_a_q[g] ##1 va_ff[g])
            else $error("target A not chosen");
        AST_VOLT_B: assert property (
            !blk && pick_pin(vs, pin_fall) |=> !volt_a_q[g])
            else $error("target B not chosen");
        AST_SW_WRITE: assert property (
            wr_slot[g] && !blk && !any_en && !seq_apply
            |=> ctrl_q[g][BIT_EN] == $past(hwdata[0]))
            else $error("enable write lost");
        AST_SEQ_TARGET: assert property (
            seq_apply && allow && !blk && es == SEL_NONE && !wr_slot[g]
            |=> ctrl_q[g][BIT_EN] == $past(ctrl_q[g][BIT_CONF]))
            else $error("sequencer target not applied");
        AST_SEQ_GATED: assert property (
            seq_apply && !allow && !wr_slot[g] && !any_en
            |=> $stable(ctrl_q[g][BIT_EN]))
            else $error("sequencer acted on gated slot");
        AST_BLOCKED: assert property (
            blk |=> $stable(ctrl_q[g]))
            else $error("merged core B register changed");
        // Only core A owns bits 7 and 4; elsewhere they must stay clear
        AST_RESERVED_ZERO: assert property (
            SW || (!ctrl_q[g][BIT_SW_CONF] && !ctrl_q[g][BIT_SW_EN]))
            else $error("reserved bit set");
    end

    // ****************************************
    // Output registers
    // ****************************************
    // Registered so every pin of the block comes from a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            on_ff   <= 4'h0;
            va_ff   <= 4'h0;
            rail_ff <= 1'b0;
        end else begin
            for (int i = 0; i < NUM_REGS; i++) begin
                on_ff[i] <= ctrl_q[i][BIT_EN] && !(i == SLOT_CORE_B && dual);
            end
            va_ff   <= volt_a_q;
            rail_ff <= ctrl_q[SLOT_CORE_A][BIT_SW_EN];
        end
    end

    assign core_b_buck_on    = on_ff[0];
    assign core_a_buck_on    = on_ff[1];
    assign processor_buck_on = on_ff[2];
    assign memory_buck_on    = on_ff[3];
    assign core_b_target_a   = va_ff[0];
    assign core_a_target_a   = va_ff[1];
    assign processor_target_a = va_ff[2];
    assign memory_target_a   = va_ff[3];
    assign processor_rail_switch_closed = rail_ff;

    // ****************************************
    // Checks
    // ****************************************
    AST_SWITCH_OUT: assert property (
        ##1 rail_ff == $past(ctrl_q[SLOT_CORE_A][BIT_SW_EN]))
        else $error("rail switch output lags bit");
    AST_SWITCH_WRITE: assert property (
        wr_slot[SLOT_CORE_A] && !seq_apply
        |-> ##2 rail_ff == $past(hwdata[BIT_SW_EN], 2))
        else $error("rail switch write not seen");
    AST_SWITCH_SEQ: assert property (
        seq_apply && !wr_slot[SLOT_CORE_A]
        |=> ctrl_q[SLOT_CORE_A][BIT_SW_EN] == $past(ctrl_q[SLOT_CORE_A][BIT_SW_CONF]))
        else $error("switch sequencer target not applied");
    AST_DUAL_OFF: assert property (
        dual [*2] |-> !on_ff[SLOT_CORE_B])
        else $error("core B on while merged");
    AST_BUS_READY: assert property (
        hreadyout && hresp == HRESP_OKAY)
        else $error("slave not ready");
    AST_IDLE_DATA: assert property (
        !(take && !hwrite) |=> hrdata == 32'h00000000)
        else $error("read data outside read");
    AST_CFG_WRITE: assert property (
        wr_cfg |=> cfg_ff == $past(hwdata[1:0]))
        else $error("config write lost");
    AST_CFG_READ: assert property (
        take && !hwrite && rd_idx == IDX_CFG |=> hrdata == {30'h0, $past(cfg_ff)})
        else $error("config read wrong");

    COV_PIN_ENABLE: cover property (
        pin_rise[0] && ctrl_q[SLOT_MEM][EN_SEL_LSB +: 2] == SEL_PIN1 ##2 on_ff[SLOT_MEM]);
    COV_VOLT_A: cover property (
        pin_rise[2] ##2 va_ff[SLOT_CORE_A]);
    COV_SEQ: cover property (
        seq_apply ##1 on_ff == 4'hf);
    COV_DUAL: cover property (
        dual && wr_slot[SLOT_CORE_B]);
    COV_PIN_DISABLE: cover property (
        pin_fall[0] ##2 !on_ff[SLOT_MEM]);

endmodule : buck_regulator_control_regs

`default_nettype wire

//--- sim/buck_regulator_control_regs_bench.sv
`default_nettype none

module buck_regulator_control_regs_bench
    import buck_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************
    // Signals
    // ****************************************
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic [2:0]  pins;
    logic        seq_apply;
    wire  [3:0]  on_q;
    wire  [3:0]  tgt_a;
    wire         rail_closed;
    int          failures;
    int          check_count;

    // Single slave: its ready is the bus ready
    assign hready = hreadyout;

    // Bit order of on_q and tgt_a: core B, core A, processor, memory
    buck_regulator_control_regs DUT (
        .hclk                         (hclk),
        .hresetn                      (hresetn),
        .hsel                         (hsel),
        .haddr                        (haddr),
        .htrans                       (htrans),
        .hwrite                       (hwrite),
        .hsize                        (hsize),
        .hwdata                       (hwdata),
        .hready                       (hready),
        .hreadyout                    (hreadyout),
        .hrdata                       (hrdata),
        .hresp                        (hresp),
        .general_pin_one              (pins[0]),
        .general_pin_two              (pins[1]),
        .general_pin_thirteen         (pins[2]),
        .seq_apply                    (seq_apply),
        .core_b_buck_on               (on_q[3]),
        .core_a_buck_on               (on_q[2]),
        .processor_buck_on            (on_q[1]),
        .memory_buck_on               (on_q[0]),
        .processor_rail_switch_closed (rail_closed),
        .core_b_target_a              (tgt_a[3]),
        .core_a_target_a              (tgt_a[2]),
        .processor_target_a           (tgt_a[1]),
        .memory_target_a              (tgt_a[0])
    );

    // ****************************************
    // Checking and bus helpers
    // ****************************************
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : check_word

    task automatic check_bit(input logic got, input logic exp, input string what);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
        end
    endtask : check_bit

    // Waits as long as it takes; only the watchdog ends a stuck transfer
    task automatic wait_ready();
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
    endtask : wait_ready

    // One single word transfer; read data taken at the edge ending the data phase
    task automatic bus_xfer(input logic wr, input logic [29:0] idx, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {idx, 2'h0};
        hwrite <= wr;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        check_bit(hresp, HRESP_OKAY, "response");
        check_bit(hreadyout, 1'b1, "ready");
    endtask : bus_xfer

    task automatic reg_write(input logic [29:0] idx, input logic [31:0] wd);
        logic [31:0] rd;
        bus_xfer(1'b1, idx, wd, rd);
    endtask : reg_write

    task automatic check_reg(input logic [29:0] idx, input logic [31:0] exp, input string what);
        logic [31:0] rd;
        bus_xfer(1'b0, idx, 32'h0, rd);
        check_word(rd, exp, what);
    endtask : check_reg

    // Outputs sit one flop behind the control byte; look 10 ns after the edge
    task automatic settle(input int n);
        repeat (n) @(posedge hclk);
        #10;
    endtask : settle

    task automatic drive_pin(input int k, input logic v, input int n);
        @(posedge hclk);
        pins[k] <= v;
        settle(n);
    endtask : drive_pin

    task automatic pulse_seq();
        @(posedge hclk);
        seq_apply <= 1'b1;
        @(posedge hclk);
        seq_apply <= 1'b0;
        settle(2);
    endtask : pulse_seq

    // Config first, since merged mode would drop the core B write
    task automatic clear_all();
        reg_write(IDX_CFG, 32'h0);
        for (int i = 0; i < NUM_REGS; i++) reg_write(SLOT_IDX[i], 32'h0);
        settle(2);
    endtask : clear_all

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        for (int i = 0; i < NUM_REGS; i++) check_reg(SLOT_IDX[i], 32'h0, "reset value");
        check_word({28'h0, on_q}, 32'h0, "enables after reset");
    endtask : t_reset

    task automatic t_rw();
        for (int i = 0; i < NUM_REGS; i++) begin
            reg_write(SLOT_IDX[i], 32'hffff_ffff);
            check_reg(SLOT_IDX[i], (i == SLOT_CORE_A) ? 32'(MASK_FULL) : 32'(MASK_PLAIN), "readback");
        end
        settle(2);
        check_word({28'h0, on_q}, 32'hf, "enables on");
        check_bit(rail_closed, 1'b1, "switch closed");
        clear_all();
        check_word({28'h0, on_q}, 32'h0, "enables off");
        check_bit(rail_closed, 1'b0, "switch open");
        reg_write(30'h3ff, 32'h1);
        check_reg(30'h3ff, 32'h0, "unmapped read");
    endtask : t_rw

    // Processor is pin owned, so the sequencer must leave it alone
    task automatic t_seq();
        reg_write(SLOT_IDX[0], 32'h08);
        reg_write(SLOT_IDX[1], 32'h88);
        reg_write(SLOT_IDX[2], 32'h0a);
        reg_write(SLOT_IDX[3], 32'h08);
        pulse_seq();
        check_word({28'h0, on_q}, 32'hc, "sequencer apply");
        check_bit(rail_closed, 1'b1, "sequencer switch");
        check_reg(SLOT_IDX[SLOT_CORE_A], 32'h99, "targets kept");
        reg_write(IDX_CFG, 32'h2);
        pulse_seq();
        check_word({28'h0, on_q}, 32'hd, "memory default supply");
        clear_all();
    endtask : t_seq

    task automatic t_pins();
        for (int s = 1; s <= 3; s++) begin
            reg_write(SLOT_IDX[SLOT_MEM], 32'(s * 32'h22));
            reg_write(SLOT_IDX[2], 32'(s * 32'h20));
            drive_pin(s - 1, 1'b1, 10);
            drive_pin(s - 1, 1'b0, 30);
            check_bit(on_q[0], 1'b0, "glitch ignored");
            drive_pin(s - 1, 1'b1, 30);
            check_bit(on_q[0], 1'b1, "pin enables");
            check_bit(tgt_a[0], 1'b1, "pin picks target a");
            check_word({28'h0, tgt_a}, 32'h3, "targets follow selectors");
            check_bit(on_q[1], 1'b0, "unselected stays off");
            check_reg(SLOT_IDX[SLOT_MEM], 32'(s * 32'h22 + 1), "pin sets enable bit");
            check_reg(IDX_STAT, (32'h1 << (STAT_PIN_LSB + s - 1)) | 32'h188, "status word");
            drive_pin(s - 1, 1'b0, 30);
            check_bit(on_q[0], 1'b0, "pin disables");
            check_bit(tgt_a[0], 1'b0, "pin picks target b");
            check_word({28'h0, tgt_a}, 32'h0, "targets back to b");
        end
        clear_all();
    endtask : t_pins

    task automatic t_dual();
        reg_write(SLOT_IDX[SLOT_CORE_B], 32'h01);
        settle(2);
        check_bit(on_q[3], 1'b1, "core b on");
        reg_write(IDX_CFG, 32'h1);
        settle(2);
        check_bit(on_q[3], 1'b0, "core b off when merged");
        check_reg(SLOT_IDX[SLOT_CORE_B], 32'h0, "core b hidden when merged");
        check_reg(IDX_CFG, 32'h1, "config readback");
        reg_write(SLOT_IDX[SLOT_CORE_B], 32'h0);
        reg_write(IDX_CFG, 32'h0);
        check_reg(SLOT_IDX[SLOT_CORE_B], 32'h1, "merged write dropped");
    endtask : t_dual

    // ****************************************
    // Run control
    // ****************************************
    task automatic complete_run();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run

    always #50 hclk = ~hclk;

    initial begin
        hclk        = 1'b0;
        hresetn     = 1'b0;
        hsel        = 1'b0;
        haddr       = 32'h0;
        htrans      = 2'h0;
        hwrite      = 1'b0;
        hsize       = 3'h2;
        hwdata      = 32'h0;
        pins        = 3'h0;
        seq_apply   = 1'b0;
        failures    = 0;
        check_count = 0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_rw();
        t_seq();
        t_pins();
        t_dual();
        complete_run();
    end

    // About 500 cycles are needed; 20000 leaves ample margin
    initial begin
        #2000000;
        failures++;
        $display("unexpected at %0t: watchdog expired", $time);
        complete_run();
    end

endmodule : buck_regulator_control_regs_bench

`default_nettype wire
